// ==== mtc_common_ctrl.sv ====
// Behaviour
// - run bits 4..0 start or halt counters
// - reset and standby load run register E0
// - run/sync bits 7..5 always read one
// - reset and standby load sync register E0
// - lockstep channels preset and clear together
// - independent channel presets and clears alone
// - mode register resets 80, bit7 reads one
// - phase mode: ch2 counts both pin edges
// - phase mode ignores internal clock selection
// - phase mode keeps clear, compare, flags
// - overflow select: overflow only, else both
// - mode bits 4..2 select pulse mode
// - pulse pin: high at A, low at B
// - combo pwm overrides ch3/ch4 pulse bits
// - mode bits 1..0 pulse mode ch1/ch0
// - combo field: 0x normal, 1x combined
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module mtc_common_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic standby,
  input wire logic phase_input_a,
  input wire logic phase_input_b,
  output logic [4:0] channel_a_pin,
  output logic [4:0] channel_a_pin_oe,
  output logic irq
);
  import mtc_pkg::*;

  function automatic logic [7:0] mtc_wr(input logic [7:0] w, input logic [7:0] m, input logic [7:0] r);
    return (w & m) | (r & ~m);
  endfunction

  function automatic logic mtc_win(input logic [7:0] a, input logic [2:0] w);
    return (a[7:5] == w) && (a[4:2] < 3'h5);
  endfunction

  // ==========================================================
  // bus slave: one wait state so a read always sees the prior write
  mtc_bus_e bus_state;
  logic [7:0] d_addr;
  logic d_wr;
  logic d_rd;
  logic accept;
  logic wr_stb;
  logic rd_stb;

  assign accept = hsel & htrans[1] & hready;
  assign wr_stb = (bus_state == MTC_DATA) & d_wr;
  assign rd_stb = (bus_state == MTC_DATA) & d_rd;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= MTC_IDLE;
      hreadyout <= 1'b1;
      d_addr <= 8'h00;
      d_wr <= 1'b0;
      d_rd <= 1'b0;
    end else begin
      unique case (bus_state)
        MTC_IDLE: begin
          if (accept) begin
            bus_state <= MTC_DATA;
            hreadyout <= 1'b0;
            d_addr <= haddr[7:0];
            // sub-word writes are dropped, the register keeps its value
            d_wr <= hwrite & (hsize == MTC_HSIZE_WORD);
            d_rd <= ~hwrite;
          end
        end
        MTC_DATA: begin
          bus_state <= MTC_IDLE;
          hreadyout <= 1'b1;
          d_wr <= 1'b0;
          d_rd <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ==========================================================
  // control registers
  logic [7:0] run_ctrl;
  logic [7:0] sync_sel;
  logic [7:0] mode_sel;
  logic [7:0] combo_ctrl;
  logic [4:0] clear_en;
  logic [5:0] irq_mask;
  logic ph_mode;
  logic ovsel;
  logic combo_pwm;

  assign ph_mode = mode_sel[MTC_MODE_PHASE];
  assign ovsel = mode_sel[MTC_MODE_OVSEL];
  assign combo_pwm = combo_ctrl[MTC_COMBO_HI];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_ctrl <= MTC_RUN_RST;
      sync_sel <= MTC_SYNC_RST;
      mode_sel <= MTC_MODE_RST;
      combo_ctrl <= MTC_COMBO_RST;
    end else if (standby) begin
      run_ctrl <= MTC_RUN_RST;
      sync_sel <= MTC_SYNC_RST;
      mode_sel <= MTC_MODE_RST;
      combo_ctrl <= MTC_COMBO_RST;
    end else if (wr_stb) begin
      // reserved bits are rebuilt from the reset pattern on every write
      if (d_addr == MTC_OFF_RUN) run_ctrl <= mtc_wr(hwdata[7:0], MTC_RUN_WMASK, MTC_RUN_RST);
      if (d_addr == MTC_OFF_SYNC) sync_sel <= mtc_wr(hwdata[7:0], MTC_SYNC_WMASK, MTC_SYNC_RST);
      if (d_addr == MTC_OFF_MODE) mode_sel <= mtc_wr(hwdata[7:0], MTC_MODE_WMASK, MTC_MODE_RST);
      if (d_addr == MTC_OFF_COMBO) combo_ctrl <= mtc_wr(hwdata[7:0], MTC_COMBO_WMASK, MTC_COMBO_RST);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clear_en <= MTC_CLREN_RST;
      irq_mask <= MTC_IRQ_RST;
    end else if (wr_stb) begin
      if (d_addr == MTC_OFF_CLREN) clear_en <= hwdata[4:0];
      if (d_addr == MTC_OFF_MASK) irq_mask <= hwdata[5:0];
    end
  end

  // ==========================================================
  // phase inputs: three-stage synchronisers, level taken when 2nd and 3rd agree
  logic [2:0] pa_s;
  logic [2:0] pb_s;
  logic pa_lvl;
  logic pb_lvl;
  logic a_new;
  logic b_new;
  logic a_chg;
  logic b_chg;
  logic ph_edge;
  logic ph_up;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pa_s <= 3'h0;
      pb_s <= 3'h0;
      pa_lvl <= 1'b0;
      pb_lvl <= 1'b0;
    end else begin
      pa_s <= {pa_s[1:0], phase_input_a};
      pb_s <= {pb_s[1:0], phase_input_b};
      pa_lvl <= a_new;
      pb_lvl <= b_new;
    end
  end

  assign a_new = (pa_s[1] == pa_s[2]) ? pa_s[2] : pa_lvl;
  assign b_new = (pb_s[1] == pb_s[2]) ? pb_s[2] : pb_lvl;
  assign a_chg = a_new ^ pa_lvl;
  assign b_chg = b_new ^ pb_lvl;
  // both pins moving at once has no defined direction and is dropped
  assign ph_edge = a_chg ^ b_chg;
  assign ph_up = a_chg ? (a_new ^ pb_lvl) : ~(b_new ^ pa_lvl);

  // ==========================================================
  // channel counters
  logic [15:0] cnt [5];
  logic [15:0] cmp_a [5];
  logic [15:0] cmp_b [5];
  logic [4:0] match_a;
  logic [4:0] match_b;
  logic [4:0] preset_ch;
  logic [4:0] load;
  logic [4:0] clr_own;
  logic [4:0] clr;
  logic [4:0] step;
  logic [4:0] up;
  logic ch2_ovf;
  logic ch2_udf;
  logic ovf_set;

  always_comb begin
    for (int c = 0; c < 5; c++) begin
      match_a[c] = run_ctrl[c] && (cnt[c] == cmp_a[c]);
      match_b[c] = run_ctrl[c] && (cnt[c] == cmp_b[c]);
      preset_ch[c] = wr_stb && mtc_win(d_addr, MTC_WIN_CNT) && (d_addr[4:2] == 3'(c));
      clr_own[c] = clear_en[c] & match_a[c];
      step[c] = run_ctrl[c];
      up[c] = 1'b1;
    end
    // phase counting replaces the internal clock for channel 2
    if (ph_mode) begin
      step[MTC_PHASE_CH] = run_ctrl[MTC_PHASE_CH] & ph_edge;
      up[MTC_PHASE_CH] = ph_up;
    end
  end

  // lockstep channels share presets and clears; others stay isolated
  assign load = preset_ch | (sync_sel[4:0] & {5{|(preset_ch & sync_sel[4:0])}});
  assign clr = clr_own | (sync_sel[4:0] & {5{|(clr_own & sync_sel[4:0])}});

  assign ch2_ovf = step[2] & up[2] & (cnt[2] == MTC_CNT_MAX) & ~load[2] & ~clr[2];
  assign ch2_udf = step[2] & ~up[2] & (cnt[2] == MTC_CNT_RST) & ~load[2] & ~clr[2];
  assign ovf_set = ch2_ovf | (ch2_udf & ~ovsel);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int c = 0; c < 5; c++) begin
        cnt[c] <= MTC_CNT_RST;
      end
    end else begin
      for (int c = 0; c < 5; c++) begin
        if (load[c]) begin
          cnt[c] <= hwdata[15:0];
        end else if (clr[c]) begin
          cnt[c] <= MTC_CNT_RST;
        end else if (step[c]) begin
          cnt[c] <= up[c] ? cnt[c] + 16'h0001 : cnt[c] - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int c = 0; c < 5; c++) begin
        cmp_a[c] <= MTC_CMP_RST;
        cmp_b[c] <= MTC_CMP_RST;
      end
    end else if (wr_stb) begin
      for (int c = 0; c < 5; c++) begin
        if (mtc_win(d_addr, MTC_WIN_CMPA) && d_addr[4:2] == 3'(c)) cmp_a[c] <= hwdata[15:0];
        if (mtc_win(d_addr, MTC_WIN_CMPB) && d_addr[4:2] == 3'(c)) cmp_b[c] <= hwdata[15:0];
      end
    end
  end

  // ==========================================================
  // pulse outputs
  logic [4:0] pwm_eff;

  assign pwm_eff = mode_sel[4:0] & ~{combo_pwm, combo_pwm, 3'h0};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_a_pin <= 5'h00;
      channel_a_pin_oe <= 5'h00;
    end else begin
      channel_a_pin_oe <= pwm_eff;
      for (int c = 0; c < 5; c++) begin
        if (!pwm_eff[c]) begin
          channel_a_pin[c] <= 1'b0;
        end else if (match_a[c]) begin
          channel_a_pin[c] <= 1'b1;
        end else if (match_b[c]) begin
          channel_a_pin[c] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // interrupts: bit0 channel 2 overflow flag, bits 5..1 compare A of ch0..4
  logic [5:0] irq_status;
  logic [5:0] irq_set;
  logic stat_rd;

  assign irq_set = {match_a, ovf_set};
  assign stat_rd = rd_stb && (d_addr == MTC_OFF_STAT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= MTC_IRQ_RST;
    end else if (stat_rd) begin
      // an event in the clearing cycle survives the read
      irq_status <= irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ==========================================================
  // read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_stb) begin
      hrdata <= 32'h0000_0000;
      if (d_addr == MTC_OFF_RUN) hrdata[7:0] <= run_ctrl;
      if (d_addr == MTC_OFF_SYNC) hrdata[7:0] <= sync_sel;
      if (d_addr == MTC_OFF_MODE) hrdata[7:0] <= mode_sel;
      if (d_addr == MTC_OFF_COMBO) hrdata[7:0] <= combo_ctrl;
      if (d_addr == MTC_OFF_CLREN) hrdata[4:0] <= clear_en;
      if (d_addr == MTC_OFF_STAT) hrdata[5:0] <= irq_status;
      if (d_addr == MTC_OFF_MASK) hrdata[5:0] <= irq_mask;
      for (int c = 0; c < 5; c++) begin
        if (d_addr[4:2] == 3'(c)) begin
          if (mtc_win(d_addr, MTC_WIN_CNT)) hrdata[15:0] <= cnt[c];
          if (mtc_win(d_addr, MTC_WIN_CMPA)) hrdata[15:0] <= cmp_a[c];
          if (mtc_win(d_addr, MTC_WIN_CMPB)) hrdata[15:0] <= cmp_b[c];
        end
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking mtc_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_RUN_HALT: assert property (!run_ctrl[0] && !load[0] && !clr[0] |=> cnt[0] == $past(cnt[0]))
    else $error("halted channel 0 counter moved");
  AST_RUN_COUNT: assert property (run_ctrl[1] && !load[1] && !clr[1] |=> cnt[1] == $past(cnt[1]) + 16'h0001)
    else $error("running channel 1 did not step");
  AST_RESERVED_ONES: assert property (run_ctrl[7:5] == 3'h7 && sync_sel[7:5] == 3'h7)
    else $error("reserved run or sync bits not one");
  AST_MODE_TOP: assert property (wr_stb && d_addr == MTC_OFF_MODE |=> mode_sel[7])
    else $error("mode bit 7 lost after write");
  AST_STANDBY: assert property (standby |=> run_ctrl == MTC_RUN_RST && sync_sel == MTC_SYNC_RST
    && mode_sel == MTC_MODE_RST)
    else $error("standby did not restore registers");
  AST_SYNC_PRESET: assert property (preset_ch[0] && sync_sel[0] && sync_sel[2]
    |=> cnt[2] == $past(hwdata[15:0]))
    else $error("lockstep channel 2 missed preset");
  AST_INDEP_PRESET: assert property (preset_ch[0] && !sync_sel[0] && !preset_ch[4] |-> !load[4])
    else $error("independent preset leaked to channel 4");
  AST_PHASE_UP: assert property (ph_mode && run_ctrl[2] && a_chg && !b_chg && (a_new != pb_lvl)
    && !load[2] && !clr[2] |=> cnt[2] == $past(cnt[2]) + 16'h0001)
    else $error("phase count did not step up");
  AST_PHASE_QUIET: assert property (ph_mode && !ph_edge && !load[2] && !clr[2] |=> $stable(cnt[2]))
    else $error("phase mode counted without a pin edge");
  AST_PHASE_CLEAR: assert property (ph_mode && clr[2] && !load[2] |=> cnt[2] == MTC_CNT_RST)
    else $error("clear ignored in phase mode");
  AST_UNDERFLOW: assert property (ch2_udf && !stat_rd |=> irq_status[MTC_STAT_OVF] == !$past(ovsel)
    || $past(irq_status[MTC_STAT_OVF]))
    else $error("overflow flag wrong on underflow");
  AST_PWM_HIGH: assert property (pwm_eff[1] && match_a[1] |=> channel_a_pin[1])
    else $error("pulse pin not set at compare A");
  AST_PWM_LOW: assert property (pwm_eff[3] && match_b[3] && !match_a[3] |=> !channel_a_pin[3])
    else $error("pulse pin not cleared at compare B");
  AST_COMBO: assert property (combo_pwm |=> !channel_a_pin_oe[4] && !channel_a_pin_oe[3])
    else $error("pulse bits not overridden");

  COV_PHASE_DOWN: cover property (ph_mode && run_ctrl[2] && ph_edge && !ph_up);
  COV_SYNC_CLEAR: cover property (|(clr_own & sync_sel[4:0]) && sync_sel[1] && sync_sel[2]);
  COV_PWM_CYCLE: cover property (channel_a_pin[0] ##[1:40] !channel_a_pin[0]);
  COV_IRQ: cover property (irq ##1 stat_rd);
endmodule
`default_nettype wire

// ==== mtc_pkg.sv ====
`default_nettype none
package mtc_pkg;
  // ==========================================================
  // register byte addresses (low byte of haddr)
  localparam logic [7:0] MTC_OFF_RUN = 8'h00;
  localparam logic [7:0] MTC_OFF_SYNC = 8'h04;
  localparam logic [7:0] MTC_OFF_MODE = 8'h08;
  localparam logic [7:0] MTC_OFF_COMBO = 8'h0C;
  localparam logic [7:0] MTC_OFF_CLREN = 8'h10;
  localparam logic [7:0] MTC_OFF_STAT = 8'h14;
  localparam logic [7:0] MTC_OFF_MASK = 8'h18;
  // per-channel windows, channel index in haddr[4:2]
  localparam logic [2:0] MTC_WIN_CNT = 3'h1;
  localparam logic [2:0] MTC_WIN_CMPA = 3'h2;
  localparam logic [2:0] MTC_WIN_CMPB = 3'h3;
  // ==========================================================
  // reset values and writable masks
  localparam logic [7:0] MTC_RUN_RST = 8'hE0;
  localparam logic [7:0] MTC_SYNC_RST = 8'hE0;
  localparam logic [7:0] MTC_MODE_RST = 8'h80;
  localparam logic [7:0] MTC_COMBO_RST = 8'hC0;
  localparam logic [7:0] MTC_RUN_WMASK = 8'h1F;
  localparam logic [7:0] MTC_SYNC_WMASK = 8'h1F;
  localparam logic [7:0] MTC_MODE_WMASK = 8'h7F;
  localparam logic [7:0] MTC_COMBO_WMASK = 8'h30;
  localparam logic [4:0] MTC_CLREN_RST = 5'h00;
  localparam logic [5:0] MTC_IRQ_RST = 6'h00;
  localparam logic [15:0] MTC_CNT_RST = 16'h0000;
  localparam logic [15:0] MTC_CMP_RST = 16'hFFFF;
  localparam logic [15:0] MTC_CNT_MAX = 16'hFFFF;
  // ==========================================================
  // field positions
  localparam int MTC_MODE_PHASE = 6;
  localparam int MTC_MODE_OVSEL = 5;
  localparam int MTC_COMBO_HI = 5;
  localparam int MTC_PHASE_CH = 2;
  localparam int MTC_STAT_OVF = 0;
  localparam logic [2:0] MTC_HSIZE_WORD = 3'h2;
  // ==========================================================
  typedef enum logic {
    MTC_IDLE = 1'b0,
    MTC_DATA = 1'b1
  } mtc_bus_e;
endpackage
`default_nettype wire

// ==== mtc_encoder_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module mtc_encoder_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic step,
  input wire logic dir_up,
  input wire logic [4:0] pin,
  input wire logic [4:0] pin_oe,
  output logic phase_input_a,
  output logic phase_input_b,
  output logic [4:0] load
);
  logic [1:0] pos;
  // ==========================================================
  // encoder: one pin changes per step, a leads b when turning up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos <= 2'h0;
    end else if (step) begin
      pos <= dir_up ? pos + 2'h1 : pos - 2'h1;
    end
  end
  assign phase_input_a = pos[1] ^ pos[0];
  assign phase_input_b = pos[1];
  // ==========================================================
  // load has a pull-down, so an undriven pin reads low
  assign load = pin & pin_oe;
endmodule
`default_nettype wire

// ==== multi_channel_timer_common_control_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module multi_channel_timer_common_control_tb;
  import mtc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} mtc_row_s;
  logic hclk, hresetn, hsel, hwrite, standby, step, dir_up;
  logic hreadyout, hresp, irq, pa, pb;
  logic [31:0] haddr, hwdata, hrdata, x, y;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] pin, oe, load;
  int err_count, n_tests, w;
  mtc_row_s rows[10] = '{'{MTC_OFF_RUN, 32'hFF, 32'hFF}, '{MTC_OFF_RUN, 32'h0A, 32'hEA},
    '{MTC_OFF_RUN, 32'h00, 32'hE0}, '{MTC_OFF_SYNC, 32'hFF, 32'hFF}, '{MTC_OFF_SYNC, 32'h00, 32'hE0},
    '{MTC_OFF_MODE, 32'h7F, 32'hFF}, '{MTC_OFF_MODE, 32'h00, 32'h80}, '{MTC_OFF_COMBO, 32'hFF, 32'hF0},
    '{MTC_OFF_COMBO, 32'h00, 32'hC0}, '{8'h1C, 32'hFF, 32'h00}};

  mtc_common_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .standby(standby), .phase_input_a(pa), .phase_input_b(pb),
    .channel_a_pin(pin), .channel_a_pin_oe(oe), .irq(irq));
  mtc_encoder_model enc_u (.hclk(hclk), .hresetn(hresetn), .step(step), .dir_up(dir_up), .pin(pin),
    .pin_oe(oe), .phase_input_a(pa), .phase_input_b(pb), .load(load));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ==========================================================
  // bus and compare helpers
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // hready is looked at in the low phase, where it has settled for the coming edge
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(negedge hclk);
      k++;
      if (k > 40) begin
        err_count++;
        conclude();
      end
    end while (hreadyout !== 1'b1);
    @(posedge hclk);
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsize <= MTC_HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
    cmp("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    cmp(n, e, r);
  endtask
  function automatic logic [7:0] ra(input logic [2:0] win, input int c);
    return {win, c[2:0], 2'b00};
  endfunction
  task automatic steps(input logic up, input int n, input int gap);
    repeat (n) begin
      step <= 1'b1;
      dir_up <= up;
      @(posedge hclk);
      step <= 1'b0;
      repeat (gap) @(posedge hclk);
    end
  endtask
  task automatic width(input int c, output int wd);
    int k;
    wd = 0;
    k = 0;
    while (load[c] !== 1'b1 && k < 300) begin
      @(negedge hclk);
      k++;
    end
    while (load[c] === 1'b1 && wd < 300) begin
      @(negedge hclk);
      wd++;
    end
    // a pulse that never starts or never ends is a mismatch, not a hang
    if (k >= 300 || wd >= 300) begin
      err_count++;
      conclude();
    end
    @(posedge hclk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {hsel, hwrite, standby, step, dir_up, htrans, hsize, haddr, hwdata} = '0;
    hresetn = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk($sformatf("reg %h", rows[i].a), rows[i].a, rows[i].e);
    end
    // second reset in mid-run
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("run", MTC_OFF_RUN, 32'hE0);
    chk("sync", MTC_OFF_SYNC, 32'hE0);
    chk("mode", MTC_OFF_MODE, 32'h80);
    // lockstep presets ch0 and ch2 only
    wr(MTC_OFF_SYNC, 32'h05);
    wr(ra(MTC_WIN_CNT, 3), 32'h0777);
    wr(ra(MTC_WIN_CNT, 1), 32'h5555);
    wr(ra(MTC_WIN_CNT, 0), 32'h1234);
    chk("cnt2", ra(MTC_WIN_CNT, 2), 32'h1234);
    chk("cnt1", ra(MTC_WIN_CNT, 1), 32'h5555);
    chk("cnt3", ra(MTC_WIN_CNT, 3), 32'h0777);
    wr(MTC_OFF_SYNC, 32'h00);
    wr(MTC_OFF_RUN, 32'h01);
    xfer(1'b0, ra(MTC_WIN_CNT, 0), 32'h0, x);
    xfer(1'b0, ra(MTC_WIN_CNT, 0), 32'h0, y);
    cmp("ch0 moving", 32'h1, {31'h0, x !== y});
    chk("cnt1 halted", ra(MTC_WIN_CNT, 1), 32'h5555);
    wr(MTC_OFF_RUN, 32'h00);
    // phase counting on channel 2
    wr(MTC_OFF_MODE, 32'h40);
    wr(ra(MTC_WIN_CNT, 2), 32'h0010);
    wr(MTC_OFF_RUN, 32'h04);
    steps(1'b1, 4, 8);
    chk("cnt2 up", ra(MTC_WIN_CNT, 2), 32'h0014);
    chk("cnt2 still", ra(MTC_WIN_CNT, 2), 32'h0014);
    steps(1'b0, 2, 12);
    chk("cnt2 down", ra(MTC_WIN_CNT, 2), 32'h0012);
    // compare-A clear still acts while the pins clock channel 2
    wr(MTC_OFF_CLREN, 32'h04);
    wr(ra(MTC_WIN_CMPA, 2), 32'h0013);
    steps(1'b1, 1, 8);
    chk("cnt2 cleared", ra(MTC_WIN_CNT, 2), 32'h0000);
    wr(MTC_OFF_CLREN, 32'h00);
    wr(ra(MTC_WIN_CNT, 2), 32'h0000);
    wr(MTC_OFF_MASK, 32'h01);
    xfer(1'b0, MTC_OFF_STAT, 32'h0, x);
    steps(1'b0, 1, 8);
    cmp("irq underflow", 32'h1, {31'h0, irq});
    xfer(1'b0, MTC_OFF_STAT, 32'h0, x);
    cmp("ovf underflow", 32'h1, x & 32'h1);
    @(posedge hclk);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    wr(MTC_OFF_MODE, 32'h60);
    wr(MTC_OFF_MASK, 32'h00);
    wr(ra(MTC_WIN_CNT, 2), 32'h0000);
    xfer(1'b0, MTC_OFF_STAT, 32'h0, x);
    steps(1'b0, 1, 8);
    xfer(1'b0, MTC_OFF_STAT, 32'h0, x);
    cmp("ovf no underflow", 32'h0, x & 32'h1);
    steps(1'b1, 1, 8);
    cmp("irq masked", 32'h0, {31'h0, irq});
    wr(MTC_OFF_MASK, 32'h01);
    @(posedge hclk);
    cmp("irq unmasked", 32'h1, {31'h0, irq});
    chk("ovf overflow", MTC_OFF_STAT, 32'h01);
    // pulse output on every channel
    wr(MTC_OFF_RUN, 32'h00);
    for (int c = 0; c < 5; c++) begin
      wr(ra(MTC_WIN_CMPA, c), 32'h0010);
      wr(ra(MTC_WIN_CMPB, c), 32'h0020);
      wr(ra(MTC_WIN_CNT, c), 32'h0000);
      wr(MTC_OFF_MODE, 32'h1 << c);
      wr(MTC_OFF_RUN, 32'h1 << c);
      width(c, w);
      cmp($sformatf("pulse width ch%0d", c), 32'd16, w);
      cmp("oe", 32'h1 << c, {27'h0, oe});
      wr(MTC_OFF_RUN, 32'h00);
    end
    // combination codes against the ch3/ch4 pulse bits
    wr(MTC_OFF_MODE, 32'h18);
    for (int i = 0; i < 4; i++) begin
      wr(MTC_OFF_COMBO, i << 4);
      @(posedge hclk);
      cmp($sformatf("oe combo %0d", i), (i < 2) ? 32'h18 : 32'h0, {27'h0, oe} & 32'h18);
    end
    // standby restores run, sync and mode; the mask keeps its value
    wr(MTC_OFF_RUN, 32'h03);
    wr(MTC_OFF_SYNC, 32'h03);
    wr(MTC_OFF_MODE, 32'h05);
    standby <= 1'b1;
    @(posedge hclk);
    standby <= 1'b0;
    @(posedge hclk);
    chk("run standby", MTC_OFF_RUN, 32'hE0);
    chk("sync standby", MTC_OFF_SYNC, 32'hE0);
    chk("mode standby", MTC_OFF_MODE, 32'h80);
    chk("mask standby", MTC_OFF_MASK, 32'h01);
    conclude();
  end
endmodule
`default_nettype wire
